// ---- rstart_master.v ----
// Repeated start sequencer with bus collision detection
//
// Notes on behaviour
// - A collision is flagged when SDA is released but seen low as released SCL is first seen high.
// - In a repeated start, SDA low when SCL rises is a collision.
// - In a repeated start, SCL falling before SDA goes low is a collision.
// - Once SDA floats high, the counter loads the reload value and runs down.
// - After that count SCL is released; seen high, a low SDA is a collision.
// - SDA high after SCL release reloads the counter for another count.
// - SDA falling during that further count is not a collision.
// - SCL falling in the count before SDA is pulled low is a collision.
// - Expiry with both lines high drives SDA low and reloads the counter.
// - After the final count SCL is driven low and the sequence is done.
// - SCL held low by another party once this side releases it stalls the timing until released; the first count runs on.
// - The bus is idle only with no master active and both lines high.
`timescale 1ns/1ps
`default_nettype none
`include "rstart_consts.vh"
module rstart_master #(
  parameter RELOAD_W = `RS_RELOAD_W
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control
  input wire start_req,
  input wire [RELOAD_W-1:0] baud_reload_value,
  input wire collision_clear,
  // Status
  output reg busy,
  output reg done_pulse,
  output reg collision_flag,
  output reg bus_idle,
  // Two-wire pins, open drain
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe
);
  // ****************************************
  // Pin sampling
  // ****************************************
  wire scl_s;
  wire sda_s;
  reg scl_prev_q;
  reg sda_prev_q;
  sync2 u_sync_scl (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(scl_in),
    .sync_out(scl_s)
  );
  sync2 u_sync_sda (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(sda_in),
    .sync_out(sda_s)
  );
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire sda_fall = ~sda_s & sda_prev_q;

  // ****************************************
  // Edge memory and pin data
  // ****************************************
  // Idle level after reset avoids a false edge
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      // Open drain: data stays low, only the enables move
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  reg [2:0] state_q;
  reg [RELOAD_W-1:0] baud_rate_counter;
  wire cnt_zero = (baud_rate_counter == {RELOAD_W{1'b0}});

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= `RS_ST_IDLE;
      baud_rate_counter <= {RELOAD_W{1'b0}};
      busy <= 1'b0;
      done_pulse <= 1'b0;
      collision_flag <= 1'b0;
      bus_idle <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      done_pulse <= 1'b0;
      // A start taken this cycle already owns the bus
      bus_idle <= (state_q == `RS_ST_IDLE) & ~start_req &
        scl_s & sda_s;
      // Set wins over a clear in the same cycle
      if (collision_clear)
        collision_flag <= 1'b0;
      case (state_q)
        `RS_ST_IDLE:
        begin
          busy <= 1'b0;
          if (start_req)
          begin
            // SCL is assumed low after the previous acknowledge
            state_q <= `RS_ST_SDA_REL;
            busy <= 1'b1;
            sda_oe <= 1'b0;
            scl_oe <= 1'b1;
          end
        end
        `RS_ST_SDA_REL:
        begin
          // Stays here while another party holds SDA low
          if (sda_s)
          begin
            baud_rate_counter <= baud_reload_value;
            state_q <= `RS_ST_CNT1;
          end
        end
        `RS_ST_CNT1:
        begin
          // Count runs while this side still holds SCL low
          if (cnt_zero)
          begin
            scl_oe <= 1'b0;
            state_q <= `RS_ST_SCL_REL;
          end
          else
            baud_rate_counter <= baud_rate_counter - 1'b1;
        end
        `RS_ST_SCL_REL:
        begin
          // Waits here while another party stretches SCL
          // No limit on the wait; a stuck line needs a reset
          if (scl_s)
          begin
            // Low SDA at rising SCL means another master sends zero
            if (!sda_s || (scl_rise && !sda_s))
            begin
              collision_flag <= 1'b1;
              state_q <= `RS_ST_IDLE;
            end
            else
            begin
              baud_rate_counter <= baud_reload_value;
              state_q <= `RS_ST_CNT2;
            end
          end
        end
        `RS_ST_CNT2:
        begin
          if (scl_fall)
          begin
            collision_flag <= 1'b1;
            state_q <= `RS_ST_IDLE;
          end
          else if (sda_fall)
          begin
            // Another master's start; no collision, bus lost quietly
            state_q <= `RS_ST_IDLE;
          end
          else if (cnt_zero)
          begin
            sda_oe <= 1'b1;
            baud_rate_counter <= baud_reload_value;
            state_q <= `RS_ST_CNT3;
          end
          else
            baud_rate_counter <= baud_rate_counter - 1'b1;
        end
        `RS_ST_CNT3:
        begin
          // SCL is pulled low whatever level it has then
          if (cnt_zero)
          begin
            scl_oe <= 1'b1;
            done_pulse <= 1'b1;
            busy <= 1'b0;
            state_q <= `RS_ST_IDLE;
          end
          else
            baud_rate_counter <= baud_rate_counter - 1'b1;
        end
        default:
        begin
          state_q <= `RS_ST_IDLE;
        end
      endcase
      // Collision exits release both lines
      if ((state_q == `RS_ST_SCL_REL && scl_s && !sda_s) ||
          (state_q == `RS_ST_CNT2 && scl_fall))
      begin
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        busy <= 1'b0;
      end
      else if (state_q == `RS_ST_CNT2 && sda_fall)
      begin
        scl_oe <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rstart_consts.vh ----
// Constants for the repeated start sequencer with collision detection
`ifndef RSTART_CONSTS_VH
`define RSTART_CONSTS_VH
`define RS_RELOAD_W 8
`define RS_RELOAD_DEFAULT 8'h04
`define RS_ST_IDLE 3'h0
`define RS_ST_SDA_REL 3'h1
`define RS_ST_CNT1 3'h2
`define RS_ST_SCL_REL 3'h3
`define RS_ST_CNT2 3'h4
`define RS_ST_CNT3 3'h5
`endif

// ---- sync2.v ----
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Level in and out
  input wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg stable_q;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= 1'b1;
      stable_q <= 1'b1;
    end
    else
    begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end
  assign sync_out = stable_q;
endmodule
`default_nettype wire

// ---- twi_bus_model.sv ----
// Wired-and bus with the other parties
`timescale 1ns/1ps
`default_nettype none
module twi_bus_model (
  // Our drivers
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Other parties
  input wire logic hold_scl,
  input wire logic pull_sda,
  // Lines
  output wire logic scl,
  output wire logic sda
);
  // Pull-ups; any party may hold SCL low
  assign scl = !(scl_oe || hold_scl);
  assign sda = !(sda_oe || pull_sda);
endmodule
`default_nettype wire

// ---- rstart_monitor.sv ----
// Port checker for the repeated start sequencer
`timescale 1ns/1ps
`default_nettype none
module rstart_monitor (
  input wire clk,
  input wire sys_rst,
  input wire start_req,
  input wire collision_clear,
  input wire busy,
  input wire done_pulse,
  input wire collision_flag,
  input wire bus_idle,
  input wire scl_oe,
  input wire sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_walk: assert property (!busy && start_req
    |=> busy && scl_oe && !sda_oe) else $error("bad start");
  a_sda_low: assert property ($rose(sda_oe) |-> busy && !scl_oe)
    else $error("sda driven early");
  a_done_drive: assert property (done_pulse
    |-> scl_oe && sda_oe && !busy) else $error("bad finish");
  a_done_once: assert property (done_pulse |=> !done_pulse)
    else $error("done too long");
  a_coll_rel: assert property ($rose(collision_flag)
    |-> !scl_oe && !sda_oe && !busy) else $error("lines held");
  a_flag_hold: assert property (collision_flag && !collision_clear
    |=> collision_flag) else $error("flag lost");
  a_flag_clr: assert property (collision_clear && !busy
    |=> !collision_flag) else $error("flag stuck");
  a_idle_free: assert property (bus_idle |-> !busy)
    else $error("idle while busy");
  c_done: cover property (done_pulse);
  c_coll: cover property ($rose(collision_flag));
  c_quiet: cover property (busy ##1 !busy && !done_pulse && !collision_flag);
endmodule
`default_nettype wire

// ---- tb_i2c_repeated_start_collision.sv ----
// Bench for the repeated start sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_repeated_start_collision;
  logic clk, sys_rst, start_req, collision_clear, hold_scl, pull_sda;
  logic busy, done_pulse, collision_flag, bus_idle, scl_oe, sda_oe, scl, sda;
  logic scl_out, sda_out;
  int err_total, checks, n;
  rstart_master u_dut (.clk(clk), .sys_rst(sys_rst), .start_req(start_req),
    .baud_reload_value(8'h10), .collision_clear(collision_clear),
    .busy(busy), .done_pulse(done_pulse), .collision_flag(collision_flag),
    .bus_idle(bus_idle), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  twi_bus_model u_bus (.scl_oe(scl_oe), .sda_oe(sda_oe),
    .hold_scl(hold_scl), .pull_sda(pull_sda), .scl(scl), .sda(sda));
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task chk(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task go;
    @(posedge clk) start_req <= 1;
    @(posedge clk) start_req <= 0;
    n = 0;
    #1;
    while (scl_oe && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask
  task wait_end;
    while (busy && n < 300)
    begin
      tick(1);
      n++;
    end
    chk(busy, 0);
  endtask
  task coll_case(input logic late, input logic on_scl);
    go;
    // Late hit lands inside the second count
    if (late) tick(6);
    if (on_scl) hold_scl <= 1;
    else pull_sda <= 1;
    wait_end;
  endtask
  task clr;
    hold_scl <= 0;
    pull_sda <= 0;
    tick(4);
    chk(bus_idle, 1);
    collision_clear <= 1;
    tick(1);
    collision_clear <= 0;
    tick(1);
    chk(collision_flag, 0);
  endtask
  initial
  begin
    sys_rst = 1; start_req = 0; collision_clear = 0;
    hold_scl = 0; pull_sda = 0; err_total = 0; checks = 0;
    tick(10);
    sys_rst <= 0;
    go;
    wait_end;
    chk(done_pulse, 1);
    chk(sda_oe, 1);
    chk(n >= 51, 1);
    chk(n <= 59, 1);
    coll_case(0, 0);
    chk(collision_flag, 1);
    chk(scl_oe | sda_oe, 0);
    clr;
    coll_case(1, 1);
    chk(collision_flag, 1);
    clr;
    coll_case(1, 0);
    chk(collision_flag | done_pulse | scl_oe, 0);
    clr;
    hold_scl <= 1;
    go;
    tick(40);
    chk(busy & ~sda_oe, 1);
    hold_scl <= 0;
    wait_end;
    chk(done_pulse, 1);
    chk(scl_out | sda_out, 0);
    end_sim;
  end
  initial
  begin
    #100000;
    err_total++;
    end_sim;
  end
  task end_sim;
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule
bind rstart_master rstart_monitor u_mon (.*);
`default_nettype wire
